// >>> hdl/init2_sequencer.sv
// Notes on behaviour
// - Async mode: eight repeats per nibble
// - Sync mode: four repeats per nibble
// - First nibble is protocol revision 0100
// - Nibbles two, three: block count 0010 0000
// - Nibbles six, seven: sensor type 0000 0001
// - Nibble eight encodes axis field
// - Nibble nine encodes full-scale range
// - Nibbles 15-18 carry Julian date except day[4]; day[1] fills its bit
// - Nibbles 27-31: offset and self-test when extended
// - Last nibble: primary config high nibble when extended
// - Unfinished self-test results are sent as zeros
// - Maker, sensor info, revision, serial in order
// - Each nibble: ID then data, k times
// - Start only if no programming entry
`timescale 1ns/1ps

module init2_sequencer #(
    parameter int ASYNC_SLOT = init2_pkg::ASYNC_SLOT_CYC
) (
    // Clock and reset
    input  wire logic                 clk_in,
    input  wire logic                 reset_n_in,
    // Register port
    input  wire logic [7:0]           addr_in,
    input  wire logic [7:0]           wr_data_in,
    input  wire logic                 wr_en_in,
    input  wire logic                 rd_en_in,
    output logic [7:0]                rd_data_out,
    // Phase 1 hand-off
    input  wire logic                 phase1_done_in,
    input  wire logic                 prog_entry_in,
    // Self-test results
    input  wire init2_pkg::selftest_s selftest_in,
    // Link side
    input  wire logic                 sync_pulse_in,
    output init2_pkg::tx_word_s       tx_out,
    output logic                      busy_out,
    output logic                      phase3_start_out
);

    // ************************************************************
    // Declarations
    // ************************************************************
    logic [7:0] ctrl_r;          // Mode, axis, range
    logic [7:0] maker_code_field_r;
    logic [7:0] sensor_info_config_r;
    logic [7:0] revision_config_r;
    logic [7:0] date_config_low_r;  // {month[2:0], day[4:0]}
    logic [7:0] date_config_high_r; // {month[3], year[6:0]}
    logic [7:0] primary_config_r;
    logic [7:0] serial_r [4];    // Serial bytes 0..3

    init2_pkg::seq_state_e state_r;  // Sequencer state
    init2_pkg::seq_state_e state_nxt;

    logic [4:0]  nib_r;          // Nibble index, 0 is D1
    logic [3:0]  rep_r;          // Repeat count of current nibble
    logic [16:0] slot_cnt_r;     // Async slot timer
    logic        slot_tick;      // One cycle per transmission slot

    logic        sync_mode;      // Timing mode select
    logic [3:0]  k_val;          // Repeats for active mode

    logic        last_rep;       // Final repeat of this nibble
    logic [3:0]  cur_nibble;     // Content of current nibble
    logic        start_ok;       // Phase 2 may begin

    assign sync_mode = ctrl_r[init2_pkg::CTRL_SYNC_BIT];

    // Repeat count follows the timing mode
    assign k_val = sync_mode ? init2_pkg::K_SYNC
                             : init2_pkg::K_ASYNC;
    assign last_rep = (rep_r == k_val - 4'h1);

    // Programming entry blocks the start of phase 2
    assign start_ok = phase1_done_in && !prog_entry_in;

    // ************************************************************
    // Nibble content
    // ************************************************************
    // Axis field to nibble code
    function automatic logic [3:0] axis_code(input logic [1:0] a);
        axis_code = {a, 2'b00};
    endfunction

    // Range field to nibble code, 60g upward
    function automatic logic [3:0] range_code(input logic [1:0] r);
        range_code = init2_pkg::RANGE_BASE + {2'b00, r};
    endfunction

    // Pick the byte nibble: high when hi is set
    function automatic logic [3:0] half(input logic [7:0] b,
                                        input logic       hi);
        half = hi ? b[7:4] : b[3:0];
    endfunction

    // Content per nibble index; results are gated by readiness
    always_comb begin
        logic       ext;
        logic [9:0] off;
        logic [9:0] st;
        logic [6:0] year;
        logic [3:0] month;
        logic [4:0] day;

        ext   = ctrl_r[init2_pkg::CTRL_EXT_BIT];
        // Not yet finished results go out as zeros
        off   = (ext && selftest_in.offset_valid)
                ? selftest_in.offset : 10'h000;
        st    = (ext && selftest_in.st_valid)
                ? selftest_in.st : 10'h000;
        year  = date_config_high_r[6:0];
        month = {date_config_high_r[7], date_config_low_r[7:5]};
        day   = date_config_low_r[4:0];

        case (nib_r)
            5'h00: cur_nibble = init2_pkg::PROTO_REV;
            5'h01: cur_nibble = init2_pkg::BLOCKS_HI;
            5'h02: cur_nibble = init2_pkg::BLOCKS_LO;
            5'h03: cur_nibble = half(maker_code_field_r, 1'b1);
            5'h04: cur_nibble = half(maker_code_field_r, 1'b0);
            5'h05: cur_nibble = init2_pkg::TYPE_HI;
            5'h06: cur_nibble = init2_pkg::TYPE_LO;
            5'h07: cur_nibble = axis_code(
                       ctrl_r[init2_pkg::CTRL_AXIS_LSB +: 2]);
            5'h08: cur_nibble = range_code(
                       ctrl_r[init2_pkg::CTRL_RANGE_LSB +: 2]);
            5'h09: cur_nibble = half(sensor_info_config_r, 1'b1);
            5'h0A: cur_nibble = half(sensor_info_config_r, 1'b0);
            5'h0B: cur_nibble = half(init2_pkg::FACTORY_REV, 1'b1);
            5'h0C: cur_nibble = half(init2_pkg::FACTORY_REV, 1'b0);
            5'h0D: cur_nibble = revision_config_r[3:0];
            5'h0E: cur_nibble = year[6:3];
            5'h0F: cur_nibble = {year[2:0], month[3]};
            5'h10: cur_nibble = {month[2:0], day[1]};
            5'h11: cur_nibble = day[3:0];
            5'h12: cur_nibble = half(serial_r[0], 1'b1);
            5'h13: cur_nibble = half(serial_r[0], 1'b0);
            5'h14: cur_nibble = half(serial_r[1], 1'b1);
            5'h15: cur_nibble = half(serial_r[1], 1'b0);
            5'h16: cur_nibble = half(serial_r[2], 1'b1);
            5'h17: cur_nibble = half(serial_r[2], 1'b0);
            5'h18: cur_nibble = half(serial_r[3], 1'b1);
            5'h19: cur_nibble = half(serial_r[3], 1'b0);
            5'h1A: cur_nibble = off[3:0];
            5'h1B: cur_nibble = off[7:4];
            5'h1C: cur_nibble = {st[1:0], off[9:8]};
            5'h1D: cur_nibble = st[5:2];
            5'h1E: cur_nibble = st[9:6];
            // Zero unless extended data is on
            5'h1F: cur_nibble = ext ? primary_config_r[7:4]
                                    : 4'h0;
            default: cur_nibble = 4'h0;
        endcase
    end

    // ************************************************************
    // Slot timing
    // ************************************************************
    // Async slots come from a free timer; sync slots follow the
    // receiver's pulses, so a missing pulse stalls the sequence
    assign slot_tick = sync_mode ? sync_pulse_in
                     : (slot_cnt_r == 17'(ASYNC_SLOT - 1));

    // Slot timer, restarted while idle so the first slot is full.
    // In sync mode it still runs, but nothing reads it there,
    // so a stray count cannot disturb the receiver's pacing.
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            slot_cnt_r <= 17'h00000;
        end else if (state_r == init2_pkg::ST_IDLE || slot_tick) begin
            slot_cnt_r <= 17'h00000;
        end else begin
            slot_cnt_r <= slot_cnt_r + 17'h00001;
        end
    end

    // ************************************************************
    // Sequencer
    // ************************************************************
    // Next state: ID and data alternate on each slot.
    // DONE has no way out but reset, as phase 2 runs once
    // per power-up.
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            init2_pkg::ST_IDLE: begin
                if (start_ok) begin
                    state_nxt = init2_pkg::ST_ID;
                end
            end
            init2_pkg::ST_ID: begin
                if (slot_tick) begin
                    state_nxt = init2_pkg::ST_DATA;
                end
            end
            init2_pkg::ST_DATA: begin
                if (slot_tick) begin
                    // Done after last repeat of nibble 32
                    if (last_rep && nib_r == init2_pkg::LAST_NIB) begin
                        state_nxt = init2_pkg::ST_DONE;
                    end else begin
                        state_nxt = init2_pkg::ST_ID;
                    end
                end
            end
            init2_pkg::ST_DONE: state_nxt = init2_pkg::ST_DONE;
            default: state_nxt = init2_pkg::ST_IDLE;
        endcase
    end

    // State register
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            state_r <= init2_pkg::ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Nibble index and repeat count
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            nib_r <= 5'h00;
            rep_r <= 4'h0;
        end else if (state_r == init2_pkg::ST_IDLE) begin
            nib_r <= 5'h00;
            rep_r <= 4'h0;
        end else if (state_r == init2_pkg::ST_DATA && slot_tick) begin
            if (last_rep) begin
                // Move on only after all k pairs
                rep_r <= 4'h0;
                if (nib_r != init2_pkg::LAST_NIB) begin
                    nib_r <= nib_r + 5'h01;
                end
            end else begin
                rep_r <= rep_r + 4'h1;
            end
        end
    end

    // Link word: ID carries the wrapping 4-bit address.
    // The word holds between strobes; only valid marks a
    // new transmission, so the line driver sees few toggles.
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            tx_out <= '0;
        end else if (slot_tick && state_r == init2_pkg::ST_ID) begin
            tx_out.valid <= 1'b1;
            tx_out.word  <= init2_pkg::ID_BASE
                          + {6'h00, nib_r[3:0]};
        end else if (slot_tick && state_r == init2_pkg::ST_DATA) begin
            tx_out.valid <= 1'b1;
            tx_out.word  <= init2_pkg::DATA_BASE
                          + {6'h00, cur_nibble};
        end else begin
            tx_out.valid <= 1'b0;
        end
    end

    // Busy level and phase 3 strobe
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            busy_out         <= 1'b0;
            phase3_start_out <= 1'b0;
        end else begin
            busy_out <= (state_nxt == init2_pkg::ST_ID
                      || state_nxt == init2_pkg::ST_DATA);
            // One pulse on the move into phase 3
            phase3_start_out <= (state_r == init2_pkg::ST_DATA
                              && state_nxt == init2_pkg::ST_DONE);
        end
    end

    // ************************************************************
    // Register port
    // ************************************************************
    // Writes; allowed at any time, taken by the next nibble read.
    // Limitation: a write during a run changes any nibble not
    // yet sent, so software should finish setup before phase 1
    // ends.
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            ctrl_r               <= init2_pkg::CTRL_RST;
            maker_code_field_r   <= init2_pkg::ZERO8;
            sensor_info_config_r <= init2_pkg::ZERO8;
            revision_config_r    <= init2_pkg::ZERO8;
            date_config_low_r    <= init2_pkg::ZERO8;
            date_config_high_r   <= init2_pkg::ZERO8;
            primary_config_r     <= init2_pkg::PCFG_RST;
            for (int i = 0; i < 4; i++) begin
                serial_r[i] <= init2_pkg::ZERO8;
            end
        end else if (wr_en_in) begin
            case (addr_in)
                init2_pkg::ADDR_CTRL:  ctrl_r               <= wr_data_in;
                init2_pkg::ADDR_MAKER: maker_code_field_r   <= wr_data_in;
                init2_pkg::ADDR_SINFO: sensor_info_config_r <= wr_data_in;
                init2_pkg::ADDR_REV:   revision_config_r    <= wr_data_in;
                init2_pkg::ADDR_DATEL: date_config_low_r    <= wr_data_in;
                init2_pkg::ADDR_DATEH: date_config_high_r   <= wr_data_in;
                init2_pkg::ADDR_PCFG:  primary_config_r     <= wr_data_in;
                init2_pkg::ADDR_SER0:  serial_r[0]          <= wr_data_in;
                init2_pkg::ADDR_SER1:  serial_r[1]          <= wr_data_in;
                init2_pkg::ADDR_SER2:  serial_r[2]          <= wr_data_in;
                init2_pkg::ADDR_SER3:  serial_r[3]          <= wr_data_in;
                default: ; // Unmapped and status: ignored
            endcase
        end
    end

    // Reads answer one cycle later; unmapped reads give zero
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rd_data_out <= init2_pkg::ZERO8;
        end else if (rd_en_in) begin
            case (addr_in)
                init2_pkg::ADDR_CTRL:   rd_data_out <= ctrl_r;
                init2_pkg::ADDR_MAKER:  rd_data_out <= maker_code_field_r;
                init2_pkg::ADDR_SINFO:  rd_data_out <= sensor_info_config_r;
                init2_pkg::ADDR_REV:    rd_data_out <= revision_config_r;
                init2_pkg::ADDR_DATEL:  rd_data_out <= date_config_low_r;
                init2_pkg::ADDR_DATEH:  rd_data_out <= date_config_high_r;
                init2_pkg::ADDR_PCFG:   rd_data_out <= primary_config_r;
                init2_pkg::ADDR_SER0:   rd_data_out <= serial_r[0];
                init2_pkg::ADDR_SER1:   rd_data_out <= serial_r[1];
                init2_pkg::ADDR_SER2:   rd_data_out <= serial_r[2];
                init2_pkg::ADDR_SER3:   rd_data_out <= serial_r[3];
                // Live sequencer state for software
                init2_pkg::ADDR_STATUS: rd_data_out <=
                    {(state_r == init2_pkg::ST_DONE),
                     (state_r == init2_pkg::ST_ID
                      || state_r == init2_pkg::ST_DATA),
                     1'b0, nib_r};
                default: rd_data_out <= init2_pkg::ZERO8;
            endcase
        end else begin
            rd_data_out <= init2_pkg::ZERO8;
        end
    end

endmodule

// >>> hdl/init2_pkg.sv
// ********
// Shared constants for the phase 2 sequencer
// ********
package init2_pkg;

    // ********
    // Clock and slot timing
    // ********
    localparam int  CLK_MHZ          = 250;   // Core clock rate
    localparam int  ASYNC_SLOT_NS    = 228000; // Asynchronous slot time
    // Longest slot rounds down, with no floor at one cycle
    localparam int  ASYNC_SLOT_CYC   = (ASYNC_SLOT_NS * CLK_MHZ) / 1000;

    // ********
    // Sequence geometry
    // ********
    localparam int  NIBBLE_COUNT     = 32;    // Data nibbles sent
    localparam logic [3:0] K_ASYNC   = 4'h8;  // Repeats, async mode
    localparam logic [3:0] K_SYNC    = 4'h4;  // Repeats, sync mode
    localparam logic [4:0] LAST_NIB  = 5'h1F; // Index of nibble 32

    // ********
    // Word codes on the link (10-bit)
    // ********
    localparam logic [9:0] ID_BASE   = 10'h200; // ID word plus address
    localparam logic [9:0] DATA_BASE = 10'h210; // Data word plus nibble

    // ********
    // Fixed nibble contents
    // ********
    localparam logic [3:0] PROTO_REV  = 4'h4; // Protocol revision
    localparam logic [3:0] BLOCKS_HI  = 4'h2; // Block count, high
    localparam logic [3:0] BLOCKS_LO  = 4'h0; // Block count, low
    localparam logic [3:0] TYPE_HI    = 4'h0; // Sensor type, high
    localparam logic [3:0] TYPE_LO    = 4'h1; // Sensor type, low
    localparam logic [3:0] RANGE_BASE = 4'h7; // Range code for 60g
    // Factory revision nibbles; values arbitrary
    localparam logic [7:0] FACTORY_REV = 8'h11;

    // ********
    // Register offsets
    // ********
    localparam logic [7:0] ADDR_CTRL   = 8'h00;
    localparam logic [7:0] ADDR_MAKER  = 8'h04;
    localparam logic [7:0] ADDR_SINFO  = 8'h08;
    localparam logic [7:0] ADDR_REV    = 8'h0C;
    localparam logic [7:0] ADDR_DATEL  = 8'h10;
    localparam logic [7:0] ADDR_DATEH  = 8'h14;
    localparam logic [7:0] ADDR_PCFG   = 8'h18;
    localparam logic [7:0] ADDR_SER0   = 8'h1C;
    localparam logic [7:0] ADDR_SER1   = 8'h20;
    localparam logic [7:0] ADDR_SER2   = 8'h24;
    localparam logic [7:0] ADDR_SER3   = 8'h28;
    localparam logic [7:0] ADDR_STATUS = 8'h2C;

    // ********
    // Control fields and reset values
    // ********
    localparam int  CTRL_SYNC_BIT  = 0; // Synchronous timing mode
    localparam int  CTRL_EXT_BIT   = 1; // Extended phase 2 data
    localparam int  CTRL_AXIS_LSB  = 2; // Two-bit axis field
    localparam int  CTRL_RANGE_LSB = 4; // Two-bit range field
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] PCFG_RST = 8'h20; // Upper nibble nominal
    localparam logic [7:0] ZERO8    = 8'h00;

    // ********
    // Types
    // ********
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_ID   = 2'b01,
        ST_DATA = 2'b10,
        ST_DONE = 2'b11
    } seq_state_e;

    typedef struct packed {
        logic       valid; // One-cycle strobe
        logic [9:0] word;  // Link word
    } tx_word_s;

    typedef struct packed {
        logic       offset_valid; // Raw offset is ready
        logic [9:0] offset;       // Raw offset
        logic       st_valid;     // Averaged self-test ready
        logic [9:0] st;           // Averaged self-test value
    } selftest_s;

endpackage

// >>> bench/init2_asserts.sv
`timescale 1ns/1ps
// ********
// Checker on the sequencer ports
// ********
module init2_asserts #(
    parameter int ASYNC_SLOT = 20
) (
    // Clock and reset
    input wire logic                clk_in,
    input wire logic                reset_n_in,
    // Register port
    input wire logic [7:0]          addr_in,
    input wire logic [7:0]          wr_data_in,
    input wire logic                wr_en_in,
    // Link side
    input wire logic                prog_entry_in,
    input wire logic                sync_pulse_in,
    input wire init2_pkg::tx_word_s tx_out,
    input wire logic                busy_out,
    input wire logic                phase3_start_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!reset_n_in);

    logic        sync_r; // Mode as last written
    logic        id_r;   // Last word was an ID word
    logic        done_r; // Phase 3 already entered
    logic [9:0]  cnt_r;  // Words since reset
    logic [15:0] gap_r;  // Cycles since last word

    // Shadow of the timing mode bit
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            sync_r <= 1'b0;
        end else if (wr_en_in && addr_in == init2_pkg::ADDR_CTRL) begin
            sync_r <= wr_data_in[init2_pkg::CTRL_SYNC_BIT];
        end
    end

    // Word and gap bookkeeping
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            {id_r, done_r, cnt_r, gap_r} <= '0;
        end else begin
            gap_r <= tx_out.valid ? 16'h0000 : gap_r + 16'h0001;
            if (tx_out.valid) begin
                id_r  <= !id_r;
                cnt_r <= cnt_r + 10'h001;
            end
            if (phase3_start_out) begin
                done_r <= 1'b1;
            end
        end
    end

    pulse_width_a: assert property (tx_out.valid |=> !tx_out.valid)
        else $error("strobe too long");
    id_first_a: assert property (tx_out.valid && !id_r
        |-> tx_out.word[9:4] == 6'h20) else $error("ID word missing");
    data_second_a: assert property (tx_out.valid && id_r
        |-> tx_out.word[9:4] == 6'h21) else $error("data word missing");
    sync_reply_a: assert property (sync_r && busy_out
        && sync_pulse_in |=> tx_out.valid) else $error("sync unanswered");
    sync_cause_a: assert property (sync_r && tx_out.valid
        |-> $past(sync_pulse_in)) else $error("word without sync");
    async_gap_a: assert property (!sync_r && tx_out.valid
        && cnt_r != 10'h000 |-> gap_r >= 16'(ASYNC_SLOT - 1)
        && gap_r <= 16'(ASYNC_SLOT)) else $error("async spacing wrong");
    word_total_a: assert property (phase3_start_out
        |-> cnt_r == (sync_r ? 10'h0FF : 10'h1FF) && tx_out.valid
        && !busy_out) else $error("phase 3 at wrong count");
    phase3_once_a: assert property (phase3_start_out |-> !done_r)
        else $error("phase 3 twice");
    prog_hold_a: assert property (!busy_out && prog_entry_in
        |=> !busy_out) else $error("start despite programming");
endmodule

bind init2_sequencer init2_asserts #(.ASYNC_SLOT(ASYNC_SLOT)) chk_u (
    .clk_in(clk_in), .reset_n_in(reset_n_in), .addr_in(addr_in),
    .wr_data_in(wr_data_in), .wr_en_in(wr_en_in),
    .prog_entry_in(prog_entry_in), .sync_pulse_in(sync_pulse_in),
    .tx_out(tx_out), .busy_out(busy_out),
    .phase3_start_out(phase3_start_out));

// >>> bench/init2_ecu_model.sv
`timescale 1ns/1ps
// ********
// Receiver model: steady sync pulse source
// ********
module init2_ecu_model #(
    parameter int PERIOD = 8
) (
    input  wire logic clk_in,
    input  wire logic reset_n_in,
    output logic      sync_pulse_out
);
    logic [7:0] tick_r; // Slot counter

    // Free-running slots; pulses while idle must be ignored
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            tick_r         <= 8'h00;
            sync_pulse_out <= 1'b0;
        end else begin
            tick_r <= (tick_r == 8'(PERIOD - 1)) ? 8'h00 : tick_r + 8'h01;
            sync_pulse_out <= (tick_r == 8'(PERIOD - 1));
        end
    end
endmodule

// >>> bench/psi5_init_phase2_tenbit_sequencer_bench.sv
`timescale 1ns/1ps
// ********
// Phase 2 sequencer bench
// ********
module psi5_init_phase2_tenbit_sequencer_bench;
    localparam int SLOT = 20; // Short async slot keeps runs brief
    logic                 clk_in         = 1'b0;
    logic                 reset_n_in     = 1'b0;
    logic [7:0]           addr_in        = 8'h00;
    logic [7:0]           wr_data_in     = 8'h00;
    logic                 wr_en_in       = 1'b0;
    logic                 rd_en_in       = 1'b0;
    logic                 phase1_done_in = 1'b0;
    logic                 prog_entry_in  = 1'b1;
    init2_pkg::selftest_s selftest_in    = '0;
    logic [7:0]           rd_data_out;
    logic                 sync_pulse_in;
    init2_pkg::tx_word_s  tx_out;
    logic                 busy_out;
    logic                 phase3_start_out;
    logic [7:0]           cfg [11];     // Register image, offset / 4
    logic [9:0]           tx_q [$];     // Expected link words
    logic [7:0]           rd_q [$];     // Expected read data
    logic                 rd_flag = 1'b0;
    int                   fails = 0;
    int                   compares = 0;

    always #2 clk_in = ~clk_in;

    init2_sequencer #(.ASYNC_SLOT(SLOT)) dut_u (
        .clk_in(clk_in), .reset_n_in(reset_n_in), .addr_in(addr_in),
        .wr_data_in(wr_data_in), .wr_en_in(wr_en_in), .rd_en_in(rd_en_in),
        .rd_data_out(rd_data_out), .phase1_done_in(phase1_done_in),
        .prog_entry_in(prog_entry_in), .selftest_in(selftest_in),
        .sync_pulse_in(sync_pulse_in), .tx_out(tx_out),
        .busy_out(busy_out), .phase3_start_out(phase3_start_out));
    init2_ecu_model #(.PERIOD(8)) ecu_u (.clk_in(clk_in),
        .reset_n_in(reset_n_in), .sync_pulse_out(sync_pulse_in));

    // ********
    // Shared tasks
    // ********
    task automatic chk(input logic [9:0] seen, input logic [9:0] exp);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value at %0t: saw %h not %h", $time, seen,
                     exp);
        end
    endtask

    task automatic summarize();
        $display("%0d compares, %0d fails", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_in);
        addr_in <= a;
        wr_data_in <= d;
        wr_en_in <= 1'b1;
        @(posedge clk_in);
        wr_en_in <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk_in);
        rd_q.push_back(e);
        addr_in <= a;
        rd_en_in <= 1'b1;
        @(posedge clk_in);
        rd_en_in <= 1'b0;
    endtask

    // Expected nibble from the register image and self-test inputs
    function automatic logic [3:0] nib(input int i);
        logic       ext;
        logic [9:0] off;
        logic [9:0] st;
        ext = cfg[0][init2_pkg::CTRL_EXT_BIT];
        off = ext && selftest_in.offset_valid ? selftest_in.offset : '0;
        st = ext && selftest_in.st_valid ? selftest_in.st : '0;
        case (i)
            0: return 4'h4;
            1: return 4'h2;
            2: return 4'h0;
            3: return cfg[1][7:4];
            4: return cfg[1][3:0];
            5: return 4'h0;
            6: return 4'h1;
            7: return {cfg[0][3:2], 2'b00};
            8: return 4'h7 + {2'b00, cfg[0][5:4]};
            9: return cfg[2][7:4];
            10: return cfg[2][3:0];
            11: return init2_pkg::FACTORY_REV[7:4];
            12: return init2_pkg::FACTORY_REV[3:0];
            13: return cfg[3][3:0];
            14: return cfg[5][6:3];
            15: return {cfg[5][2:0], cfg[5][7]};
            16: return {cfg[4][7:5], cfg[4][1]};
            17: return cfg[4][3:0];
            26: return off[3:0];
            27: return off[7:4];
            28: return {st[1:0], off[9:8]};
            29: return st[5:2];
            30: return st[9:6];
            31: return ext ? cfg[6][7:4] : 4'h0;
            default: return (i % 2 == 0) ? cfg[7 + (i - 18) / 2][7:4]
                                         : cfg[7 + (i - 18) / 2][3:0];
        endcase
    endfunction

    task automatic do_reset();
        reset_n_in <= 1'b0;
        prog_entry_in <= 1'b1;
        phase1_done_in <= 1'b0;
        repeat (4) @(posedge clk_in);
        reset_n_in <= 1'b1;
    endtask

    // One full phase 2 pass in the given mode
    task automatic run(input logic sync, input logic ext, input logic st_ok);
        int i, r;
        for (i = 0; i < 11; i++) begin
            rd(8'(i * 4), (i == 6) ? init2_pkg::PCFG_RST : init2_pkg::ZERO8);
        end
        wr(init2_pkg::ADDR_STATUS, 8'hFF);
        rd(init2_pkg::ADDR_STATUS, 8'h00);
        rd(8'h30, 8'h00);
        for (i = 0; i < 11; i++) begin
            cfg[i] = 8'($urandom);
        end
        cfg[0] = {2'b00, cfg[0][5:2], ext, sync};
        selftest_in <= {1'b1, 10'($urandom), st_ok, 10'($urandom)};
        for (i = 0; i < 11; i++) begin
            wr(8'(i * 4), cfg[i]);
        end
        for (i = 0; i < 11; i++) begin
            rd(8'(i * 4), cfg[i]);
        end
        for (i = 0; i < 32; i++) begin
            repeat (sync ? 4 : 8) begin
                tx_q.push_back(10'h200 + 10'(i[3:0]));
                tx_q.push_back(10'h210 + 10'(nib(i)));
            end
        end
        phase1_done_in <= 1'b1;
        repeat (10) @(posedge clk_in);
        chk(10'(busy_out), 10'h000);
        prog_entry_in <= 1'b0;
        for (r = 0; r < 30000 && phase3_start_out !== 1'b1; r++)
            @(posedge clk_in);
        chk(10'(phase3_start_out), 10'h001);
        repeat (40) @(posedge clk_in);
        chk(10'(tx_q.size()), 10'h000);
    endtask

    // ********
    // Output watchers
    // ********
    always @(posedge clk_in) begin
        if (rd_flag) begin
            chk(10'(rd_data_out), 10'(rd_q.pop_front()));
        end
        rd_flag <= rd_en_in;
        if (tx_out.valid === 1'b1) begin
            if (tx_q.size() == 0) begin
                fails++;
                $display("wrong value at %0t: extra word", $time);
            end else begin
                chk(tx_out.word, tx_q.pop_front());
            end
        end
    end

    // Sync run with extended data, then async run without
    initial begin
        void'($urandom(32'h16d5));
        do_reset();
        run(1'b1, 1'b1, 1'b0);
        do_reset();
        run(1'b0, 1'b0, 1'b1);
        summarize();
    end

    // Hang guard, about four times the expected run
    initial begin
        #200000;
        fails++;
        $display("wrong value at %0t: run timed out", $time);
        summarize();
    end
endmodule
